// [dv/fmd_decoder_asserts.sv]
// Checker for the decoder: timing and decode relations at the top ports.
// Assumes one clock domain and a decode latency of one cycle.
module fmd_decoder_asserts (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Issue side.
  input wire logic [31:0] instrWord,
  input wire logic instrValid,
  input wire logic cmpFamily,
  // Results.
  input wire logic decValid,
  input wire fmd_pkg::fmd_fmt_t fmtDecoded,
  input wire logic fpOp,
  input wire fmd_pkg::fmd_md_t mdOp,
  input wire logic mdWide,
  input wire logic mdWritesHighLow,
  input wire fmd_pkg::fmd_pc_t pcOp,
  input wire logic [18:0] pcImm,
  input wire logic reservedInstr
);
  wire logic [4:0] sub = instrWord[10:6];
  wire logic [4:0] rs = instrWord[25:21];
  wire logic mdFam = instrValid && instrWord[31:26] == 6'h00 && instrWord[5:3] == 3'h3;
  wire logic newMd = mdFam && (sub == 5'h02 || sub == 5'h03);
  wire logic pcFam = instrValid && instrWord[31:26] == 6'h3B;
  wire logic cop = instrValid && instrWord[31:26] == 6'h11;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_valid_follows: assert property (instrValid |=> decValid)
    else $error("decode result missing");
  a_idle_quiet: assert property (!instrValid |=> !decValid && !reservedInstr
    && mdOp == fmd_pkg::FMD_MD_NONE && pcOp == fmd_pkg::FMD_PC_NONE)
    else $error("result without request");
  a_old_pair_ri: assert property (mdFam && sub == 5'h00 && instrWord[15:11] == 5'h00
    |=> reservedInstr && mdOp == fmd_pkg::FMD_MD_NONE)
    else $error("old two-result form not refused");
  a_muldiv_ri: assert property (mdFam && !newMd |=> reservedInstr)
    else $error("bad sub-operation not refused");
  a_new_md_ok: assert property (newMd |=> !reservedInstr && mdOp != fmd_pkg::FMD_MD_NONE
    && mdWide == $past(instrWord[2]))
    else $error("new multiply/divide misdecoded");
  a_quot_only: assert property (mdFam && instrWord[5:0] == 6'h1A && sub == 5'h02
    |=> mdOp == fmd_pkg::FMD_MD_QUOTIENT_SIGNED && !mdWritesHighLow)
    else $error("divide not quotient only");
  a_pc_hole: assert property (pcFam && instrWord[20:17] == 4'hE
    |=> reservedInstr && pcOp == fmd_pkg::FMD_PC_NONE)
    else $error("reserved pc-relative prefix accepted");
  a_pc_upper: assert property (pcFam && instrWord[20:17] == 4'hF |=> !reservedInstr
    && pcImm == {{3{$past(instrWord[15])}}, $past(instrWord[15:0])})
    else $error("upper immediate wrong");
  a_fmt_hole: assert property (cop && !cmpFamily && (rs == 5'h12 || rs == 5'h13
    || rs == 5'h17) |=> reservedInstr)
    else $error("reserved format accepted");
  a_cmp_remap: assert property (cop && cmpFamily && rs == 5'h18
    |=> fmtDecoded == fmd_pkg::FMD_FMT_SINGLE && !reservedInstr)
    else $error("compare single not remapped");
  c_new_md: cover property (newMd ##1 decValid);
  c_old_md: cover property (mdFam && sub == 5'h00 ##1 reservedInstr);
  c_pc_op: cover property (pcFam ##1 pcOp != fmd_pkg::FMD_PC_NONE);
endmodule
bind fmd_decoder fmd_decoder_asserts u_chk (.ref_clk, .rst_n, .instrWord, .instrValid,
  .cmpFamily, .decValid, .fmtDecoded, .fpOp, .mdOp, .mdWide, .mdWritesHighLow, .pcOp,
  .pcImm, .reservedInstr);

// [dv/fmd_issue_model.sv]
// Issue stage model: hands the decoder one word per request.
// Assumes the bench changes its request just after a rising edge.
module fmd_issue_model (
  // Clock.
  input wire logic ref_clk,
  // Request from the bench.
  input wire logic [31:0] reqWord,
  input wire logic reqValid,
  input wire logic reqCmp,
  // Toward the decoder.
  output logic [31:0] instrWord,
  output logic instrValid,
  output logic cmpFamily
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] lastWord = 32'h0000_0000;
  // An idle bus shows the inverse of the last word, so stale use is caught.
  always @(posedge ref_clk)
    if (reqValid)
      lastWord <= reqWord;
  assign instrWord = reqValid ? reqWord : ~lastWord;
  assign instrValid = reqValid;
  assign cmpFamily = reqValid ? reqCmp : ~lastWord[0];
endmodule

// [dv/tb.sv]
// Directed bench for the format and multiply/divide decoder.
// Assumes the issue model passes each request to the decoder in its cycle.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] reqWord = 32'h0000_0000;
  logic reqValid = 1'b0;
  logic reqCmp = 1'b0;
  logic [31:0] instrWord;
  logic instrValid, cmpFamily, decValid, fpOp, mdWide, mdWritesHighLow, reservedInstr;
  fmd_pkg::fmd_fmt_t fmtDecoded;
  fmd_pkg::fmd_md_t mdOp;
  fmd_pkg::fmd_pc_t pcOp;
  logic [18:0] pcImm;
  int n_errors = 0;
  int cmp_count = 0;
  initial forever #4 ref_clk = ~ref_clk;
  fmd_issue_model u_issue (.ref_clk, .reqWord, .reqValid, .reqCmp, .instrWord,
    .instrValid, .cmpFamily);
  fmd_decoder dut (.ref_clk, .rst_n, .instrWord, .instrValid, .cmpFamily, .decValid,
    .fmtDecoded, .fpOp, .mdOp, .mdWide, .mdWritesHighLow, .pcOp, .pcImm, .reservedInstr);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chkV(input logic [18:0] got, input logic [18:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkF(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Sends one word and returns once its decode is on the outputs.
  task automatic dec(input logic [31:0] w, input logic c);
    @(posedge ref_clk);
    #1 reqWord = w;
    reqCmp = c;
    reqValid = 1'b1;
    @(posedge ref_clk);
    #1 reqValid = 1'b0;
    chkF(decValid, 1'b1);
  endtask
  function automatic fmd_pkg::fmd_fmt_t efmt(input int f);
    case (f)
      16: return fmd_pkg::FMD_FMT_SINGLE;
      17: return fmd_pkg::FMD_FMT_DOUBLE;
      20: return fmd_pkg::FMD_FMT_WORD;
      21: return fmd_pkg::FMD_FMT_LONG;
      22: return fmd_pkg::FMD_FMT_PAIRED;
      default: return fmd_pkg::FMD_FMT_NONE;
    endcase
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fmt();
    for (int f = 0; f < 32; f++)
    begin
      dec({6'h11, 5'(f), 21'h00_0000}, 1'b0);
      chkF(fpOp, f >= 16);
      chkV(19'(fmtDecoded), 19'(efmt(f)));
      chkF(reservedInstr, f >= 16 && !(f inside {16, 17, 20, 21}));
    end
    for (int s = 0; s < 8; s++)
    begin
      dec({6'h13, 23'h00_0000, 3'(s)}, 1'b0);
      chkV(19'(fmtDecoded), 19'(efmt(s + 16)));
      chkF(fpOp, 1'b1);
      chkF(reservedInstr, 1'b1);
    end
    dec({6'h11, 5'h18, 21'h00_0000}, 1'b1);
    chkV(19'(fmtDecoded), 19'(fmd_pkg::FMD_FMT_SINGLE));
    dec({6'h11, 5'h19, 21'h00_0000}, 1'b1);
    chkV(19'(fmtDecoded), 19'(fmd_pkg::FMD_FMT_DOUBLE));
    chkF(reservedInstr, 1'b0);
    dec({6'h11, 5'h14, 21'h00_0000}, 1'b1);
    chkF(reservedInstr, 1'b1);
  endtask
  task automatic t_md();
    logic [4:0] subs [5] = '{5'h00, 5'h00, 5'h01, 5'h04, 5'h1F};
    for (int i = 0; i < 16; i++)
    begin
      dec({21'h00_28C7, 5'(2 + i % 2), 3'h3, 3'(i / 2)}, 1'b0);
      chkV(19'(mdOp), 19'(1 + 2 * ((i / 2) % 4) + i % 2));
      chkF(mdWide, i >= 8);
      chkF(mdWritesHighLow, 1'b0);
      chkF(reservedInstr, 1'b0);
    end
    for (int k = 0; k < 5; k++)
    begin
      dec({16'h00A6, (k == 0) ? 5'h00 : 5'h07, subs[k], 3'h3, 3'(k)}, 1'b0);
      chkF(reservedInstr, 1'b1);
      chkV(19'(mdOp), 19'(fmd_pkg::FMD_MD_NONE));
    end
  endtask
  task automatic pc(input logic [20:0] lo, input fmd_pkg::fmd_pc_t op,
    input logic [18:0] imm, input logic r);
    dec({6'h3B, 5'h01, lo}, 1'b0);
    chkV(19'(pcOp), 19'(op));
    chkF(reservedInstr, r);
    if (!r)
      chkV(pcImm, imm);
  endtask
  task automatic t_pc();
    pc(21'h04_0001, fmd_pkg::FMD_PC_ADD_IMMEDIATE, 19'h4_0001, 1'b0);
    pc(21'h0C_0002, fmd_pkg::FMD_PC_WORD_LOAD, 19'h4_0002, 1'b0);
    pc(21'h10_0003, fmd_pkg::FMD_PC_UNSIGNED_WORD_LOAD, 19'h0_0003, 1'b0);
    pc(21'h1A_0004, fmd_pkg::FMD_PC_DOUBLEWORD_LOAD, 19'h6_0004, 1'b0);
    pc(21'h1C_0005, fmd_pkg::FMD_PC_NONE, 19'h0_0000, 1'b1);
    pc(21'h1E_8006, fmd_pkg::FMD_PC_ADD_UPPER_IMMEDIATE, 19'h7_8006, 1'b0);
    pc(21'h1F_1234, fmd_pkg::FMD_PC_ALIGNED_UPPER_IMMEDIATE, 19'h0_1234, 1'b0);
  endtask
  // Back-to-back words, then a reset that lands mid-stream, then idle.
  task automatic t_stream();
    @(posedge ref_clk);
    #1 reqWord = 32'h0000_0098;
    reqCmp = 1'b0;
    reqValid = 1'b1;
    @(posedge ref_clk);
    #1 reqWord = 32'h0000_0018;
    chkV(19'(mdOp), 19'(fmd_pkg::FMD_MD_PRODUCT_LOW_SIGNED));
    @(posedge ref_clk);
    #1 reqWord = 32'h2000_0000;
    chkF(reservedInstr, 1'b1);
    @(posedge ref_clk);
    #1 reqWord = 32'h0000_0018;
    chkF(reservedInstr, 1'b0);
    rst_n = 1'b0;
    #1 chkF(decValid, 1'b0);
    @(posedge ref_clk);
    #1 rst_n = 1'b1;
    @(posedge ref_clk);
    #1 reqValid = 1'b0;
    chkF(reservedInstr, 1'b1);
    @(posedge ref_clk);
    #1 chkF(decValid, 1'b0);
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_fmt();
    t_md();
    t_pc();
    t_stream();
    conclude();
  end
  initial
  begin
    #100000;
    n_errors++;
    conclude();
  end
endmodule

// [rtl/fmd_decoder.sv]
// Top of the format and multiply/divide decoder: one instruction per cycle in,
// registered decode one cycle later.
// Each result group has its own next-value logic and its own register process.
// Assumes the issue stage presents instrValid with a stable word for one cycle.
//
// How it works
// - Long format 16/17/20/21/22 are single/double/word/long/paired; 22 and the rest from 16 up reserved.
// - Short format 0/1/4/5/6 map likewise; every indexed form is reserved.
// - Compare family reads format 11000 as single, 11001 as double.
// - Old and new multiply/divide differ only by bits 10-6.
// - Sub-operation 00010 gives low/quotient, 00011 high/remainder, all variants.
// - Sub-operation 00000 with destination 00000 raises reserved-instruction.
// - Any opcode-zero 011xxx function without sub-operation 00010/00011 is reserved.
// - New divides write the quotient or the remainder, never the high/low pair.
// - Removed or moved encodings decode as reserved unless reassigned.
// - PC-relative immediate shrinks from 19 to 16 bits with longer prefix.
// - Bits 20-16 select PC-relative operation; prefix 1110 reserved.
module fmd_decoder (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Instruction from the issue stage.
  input wire logic [31:0] instrWord,
  input wire logic instrValid,
  // Compare family marker, supplied by the coprocessor function decode.
  input wire logic cmpFamily,
  // Decoded results.
  output logic decValid,
  output fmd_pkg::fmd_fmt_t fmtDecoded,
  output logic fpOp,
  output fmd_pkg::fmd_md_t mdOp,
  output logic mdWide,
  output logic mdWritesHighLow,
  output fmd_pkg::fmd_pc_t pcOp,
  output logic [18:0] pcImm,
  output logic reservedInstr
);

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  logic [5:0] opcode;
  logic [4:0] rsField;
  logic [4:0] rtField;
  logic [4:0] rdField;
  logic [4:0] subOp;
  logic [5:0] funct;
  fmd_pkg::fmd_fmt_t fmtComb;
  logic fmtRsvComb;
  logic isIndexed;

  assign opcode = instrWord[fmd_pkg::OPC_MSB:fmd_pkg::OPC_LSB];
  assign rsField = instrWord[fmd_pkg::RS_MSB:fmd_pkg::RS_LSB];
  assign rtField = instrWord[fmd_pkg::RT_MSB:fmd_pkg::RT_LSB];
  assign rdField = instrWord[fmd_pkg::RD_MSB:fmd_pkg::RD_LSB];
  assign subOp = instrWord[fmd_pkg::SUB_MSB:fmd_pkg::SUB_LSB];
  assign funct = instrWord[fmd_pkg::FN_MSB:fmd_pkg::FN_LSB];
  assign isIndexed = (opcode == fmd_pkg::OPC_FP_INDEXED);

  // ----------------------------------------
  // Format field decode
  // ----------------------------------------
  fmd_format_decode uFormat (
    .longFmt(rsField),
    .shortFmt(instrWord[fmd_pkg::SHORT_FMT_MSB:fmd_pkg::SHORT_FMT_LSB]),
    .useShort(isIndexed),
    .cmpFamily(cmpFamily),
    .fmt(fmtComb),
    .fmtReserved(fmtRsvComb)
  );

  // Sign-extends a PC-relative immediate of the given width to 19 bits.
  function automatic logic [18:0] pcImmExtend(input logic [20:0] low, input int width);
    logic [18:0] r;
    r = '0;
    for (int i = 0; i < 19; i++)
    begin
      r[i] = (i < width) ? low[i] : low[width - 1];
    end
    return r;
  endfunction

  // ----------------------------------------
  // Format group
  // ----------------------------------------
  logic fpOp_reg;
  logic fpOp_next;
  fmd_pkg::fmd_fmt_t fmt_reg;
  fmd_pkg::fmd_fmt_t fmt_next;
  logic fpRsv;

  // A reserved format is reported here and merged into the shared flag below.
  always_comb
  begin
    fpOp_next = 1'b0;
    fmt_next = fmd_pkg::FMD_FMT_NONE;
    fpRsv = 1'b0;
    if (instrValid && opcode == fmd_pkg::OPC_FP_COPROC && rsField >= fmd_pkg::FMT_SINGLE)
    begin
      // Format values below 16 are move/transfer forms handled elsewhere.
      fpOp_next = 1'b1;
      fmt_next = fmtComb;
      // Paired single is removed, so it traps like any other reserved format.
      fpRsv = fmtRsvComb || fmtComb == fmd_pkg::FMD_FMT_PAIRED;
    end
    else if (instrValid && isIndexed)
    begin
      fpOp_next = 1'b1;
      fmt_next = fmtComb;
      // Every indexed-form instruction is removed in this release.
      fpRsv = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fpOp_reg <= 1'b0;
      fmt_reg <= fmd_pkg::FMD_FMT_NONE;
    end
    else
    begin
      fpOp_reg <= fpOp_next;
      fmt_reg <= fmt_next;
    end
  end

  // ----------------------------------------
  // Multiply/divide group
  // ----------------------------------------
  fmd_pkg::fmd_md_t md_reg;
  fmd_pkg::fmd_md_t md_next;
  logic mdWide_reg;
  logic mdWide_next;
  logic hiLo_reg;
  logic hiLo_next;
  logic mdRsv;

  always_comb
  begin
    md_next = fmd_pkg::FMD_MD_NONE;
    mdWide_next = 1'b0;
    hiLo_next = 1'b0;
    mdRsv = 1'b0;
    if (instrValid && opcode == fmd_pkg::OPC_SPECIAL && funct[5:3] == fmd_pkg::FN_MULDIV_HI)
    begin
      // Only the sub-operation field separates old and new forms.
      if (subOp == fmd_pkg::SUB_LOW || subOp == fmd_pkg::SUB_HIGH)
      begin
        // Bit 2 of the function code picks the 64-bit variant.
        mdWide_next = funct[2];
        // The index packs the unsigned and divide selects with the high/low choice.
        unique case ({funct[1:0], subOp[0]})
          3'h0: md_next = fmd_pkg::FMD_MD_PRODUCT_LOW_SIGNED;
          3'h1: md_next = fmd_pkg::FMD_MD_PRODUCT_HIGH_SIGNED;
          3'h2: md_next = fmd_pkg::FMD_MD_PRODUCT_LOW_UNSIGNED;
          3'h3: md_next = fmd_pkg::FMD_MD_PRODUCT_HIGH_UNSIGNED;
          3'h4: md_next = fmd_pkg::FMD_MD_QUOTIENT_SIGNED;
          3'h5: md_next = fmd_pkg::FMD_MD_REMAINDER_SIGNED;
          3'h6: md_next = fmd_pkg::FMD_MD_QUOTIENT_UNSIGNED;
          3'h7: md_next = fmd_pkg::FMD_MD_REMAINDER_UNSIGNED;
        endcase
        // New forms have one destination register only.
        hiLo_next = 1'b0;
      end
      else if (subOp == fmd_pkg::SUB_OLD && rdField == fmd_pkg::RD_NONE)
      begin
        // Old two-result form that used the high/low pair.
        mdRsv = 1'b1;
      end
      else
      begin
        // Every other sub-operation value in this family traps as well.
        mdRsv = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      md_reg <= fmd_pkg::FMD_MD_NONE;
      mdWide_reg <= 1'b0;
      hiLo_reg <= 1'b0;
    end
    else
    begin
      md_reg <= md_next;
      mdWide_reg <= mdWide_next;
      hiLo_reg <= hiLo_next;
    end
  end

  // ----------------------------------------
  // PC-relative group
  // ----------------------------------------
  fmd_pkg::fmd_pc_t pc_reg;
  fmd_pkg::fmd_pc_t pc_next;
  logic [18:0] pcImm_reg;
  logic [18:0] pcImm_next;
  logic pcRsv;

  // Immediates are sign-extended so the address adder always sees 19 bits.
  always_comb
  begin
    pc_next = fmd_pkg::FMD_PC_NONE;
    pcImm_next = '0;
    pcRsv = 1'b0;
    if (instrValid && opcode == fmd_pkg::OPC_PC_REL)
    begin
      // Longer prefixes leave fewer bits for the immediate.
      unique casez (rtField)
        5'b00???:
        begin
          pc_next = fmd_pkg::FMD_PC_ADD_IMMEDIATE;
          pcImm_next = pcImmExtend(instrWord[20:0], fmd_pkg::IMM_W19);
        end
        5'b01???:
        begin
          pc_next = fmd_pkg::FMD_PC_WORD_LOAD;
          pcImm_next = pcImmExtend(instrWord[20:0], fmd_pkg::IMM_W19);
        end
        5'b10???:
        begin
          pc_next = fmd_pkg::FMD_PC_UNSIGNED_WORD_LOAD;
          pcImm_next = pcImmExtend(instrWord[20:0], fmd_pkg::IMM_W19);
        end
        5'b110??:
        begin
          pc_next = fmd_pkg::FMD_PC_DOUBLEWORD_LOAD;
          pcImm_next = pcImmExtend(instrWord[20:0], fmd_pkg::IMM_W18);
        end
        // The 1110 prefix has no operation, so only the flag is raised.
        5'b1110?: pcRsv = 1'b1;
        5'b11110:
        begin
          pc_next = fmd_pkg::FMD_PC_ADD_UPPER_IMMEDIATE;
          pcImm_next = pcImmExtend(instrWord[20:0], fmd_pkg::IMM_W16);
        end
        5'b11111:
        begin
          pc_next = fmd_pkg::FMD_PC_ALIGNED_UPPER_IMMEDIATE;
          pcImm_next = pcImmExtend(instrWord[20:0], fmd_pkg::IMM_W16);
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_reg <= fmd_pkg::FMD_PC_NONE;
      pcImm_reg <= '0;
    end
    else
    begin
      pc_reg <= pc_next;
      pcImm_reg <= pcImm_next;
    end
  end

  // ----------------------------------------
  // Status group
  // ----------------------------------------
  logic decValid_reg;
  logic decValid_next;
  logic rsv_reg;
  logic rsv_next;

  always_comb
  begin
    // The valid flag follows the request whatever the word holds.
    decValid_next = instrValid;
    // Only one family can match a word, so the flags simply merge.
    rsv_next = fpRsv || mdRsv || pcRsv;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      decValid_reg <= 1'b0;
      rsv_reg <= 1'b0;
    end
    else
    begin
      decValid_reg <= decValid_next;
      rsv_reg <= rsv_next;
    end
  end

  // ----------------------------------------
  // Result outputs
  // ----------------------------------------
  assign decValid = decValid_reg;
  assign fmtDecoded = fmt_reg;
  assign fpOp = fpOp_reg;
  assign mdOp = md_reg;
  assign mdWide = mdWide_reg;
  assign mdWritesHighLow = hiLo_reg;
  assign pcOp = pc_reg;
  assign pcImm = pcImm_reg;
  assign reservedInstr = rsv_reg;

endmodule

// [rtl/fmd_format_decode.sv]
// Decodes a 5-bit long or 3-bit short floating-point format field.
// Purely combinational; the caller registers the results.
module fmd_format_decode (
  // Long format field from the coprocessor form.
  input wire logic [4:0] longFmt,
  // Short format field from the indexed form.
  input wire logic [2:0] shortFmt,
  input wire logic useShort,
  // Compare family remaps codes 11000 and 11001 to single and double.
  input wire logic cmpFamily,
  // Decoded format.
  output fmd_pkg::fmd_fmt_t fmt,
  output logic fmtReserved
);

  always_comb
  begin
    fmt = fmd_pkg::FMD_FMT_NONE;
    fmtReserved = 1'b0;
    if (useShort)
    begin
      unique case (shortFmt)
        fmd_pkg::SFMT_SINGLE: fmt = fmd_pkg::FMD_FMT_SINGLE;
        fmd_pkg::SFMT_DOUBLE: fmt = fmd_pkg::FMD_FMT_DOUBLE;
        fmd_pkg::SFMT_WORD: fmt = fmd_pkg::FMD_FMT_WORD;
        fmd_pkg::SFMT_LONG: fmt = fmd_pkg::FMD_FMT_LONG;
        fmd_pkg::SFMT_PAIRED: fmt = fmd_pkg::FMD_FMT_PAIRED;
        default: fmtReserved = 1'b1;
      endcase
    end
    else if (cmpFamily)
    begin
      unique case (longFmt)
        fmd_pkg::FMT_CMP_SINGLE: fmt = fmd_pkg::FMD_FMT_SINGLE;
        fmd_pkg::FMT_CMP_DOUBLE: fmt = fmd_pkg::FMD_FMT_DOUBLE;
        default: fmtReserved = 1'b1;
      endcase
    end
    else
    begin
      unique case (longFmt)
        fmd_pkg::FMT_SINGLE: fmt = fmd_pkg::FMD_FMT_SINGLE;
        fmd_pkg::FMT_DOUBLE: fmt = fmd_pkg::FMD_FMT_DOUBLE;
        fmd_pkg::FMT_WORD: fmt = fmd_pkg::FMD_FMT_WORD;
        fmd_pkg::FMT_LONG: fmt = fmd_pkg::FMD_FMT_LONG;
        fmd_pkg::FMT_PAIRED: fmt = fmd_pkg::FMD_FMT_PAIRED;
        default: fmtReserved = 1'b1;
      endcase
    end
  end

endmodule

// [rtl/fmd_pkg.sv]
// Shared constants and types for the floating-point format and multiply/divide decoder.
// Assumes a 32-bit instruction word supplied by the fetch/issue stage.
package fmd_pkg;

  // ----------------------------------------
  // Instruction fields
  // ----------------------------------------
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int RS_MSB = 25;
  localparam int RS_LSB = 21;
  localparam int RT_MSB = 20;
  localparam int RT_LSB = 16;
  localparam int RD_MSB = 15;
  localparam int RD_LSB = 11;
  localparam int SUB_MSB = 10;
  localparam int SUB_LSB = 6;
  localparam int FN_MSB = 5;
  localparam int FN_LSB = 0;
  localparam int SHORT_FMT_MSB = 2;
  localparam int SHORT_FMT_LSB = 0;

  // ----------------------------------------
  // Opcodes and codes
  // ----------------------------------------
  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] OPC_FP_COPROC = 6'h11;
  localparam logic [5:0] OPC_FP_INDEXED = 6'h13;
  localparam logic [5:0] OPC_PC_REL = 6'h3B;
  localparam logic [2:0] FN_MULDIV_HI = 3'h3;
  localparam logic [4:0] SUB_OLD = 5'h00;
  localparam logic [4:0] SUB_LOW = 5'h02;
  localparam logic [4:0] SUB_HIGH = 5'h03;
  localparam logic [4:0] RD_NONE = 5'h00;

  // ----------------------------------------
  // Format codes
  // ----------------------------------------
  localparam logic [4:0] FMT_SINGLE = 5'h10;
  localparam logic [4:0] FMT_DOUBLE = 5'h11;
  localparam logic [4:0] FMT_WORD = 5'h14;
  localparam logic [4:0] FMT_LONG = 5'h15;
  localparam logic [4:0] FMT_PAIRED = 5'h16;
  localparam logic [4:0] FMT_CMP_SINGLE = 5'h18;
  localparam logic [4:0] FMT_CMP_DOUBLE = 5'h19;
  localparam logic [2:0] SFMT_SINGLE = 3'h0;
  localparam logic [2:0] SFMT_DOUBLE = 3'h1;
  localparam logic [2:0] SFMT_WORD = 3'h4;
  localparam logic [2:0] SFMT_LONG = 3'h5;
  localparam logic [2:0] SFMT_PAIRED = 3'h6;

  // ----------------------------------------
  // Immediate widths in the PC-relative family
  // ----------------------------------------
  localparam int IMM_W19 = 19;
  localparam int IMM_W18 = 18;
  localparam int IMM_W16 = 16;

  typedef enum logic [2:0] {
    FMD_FMT_NONE,
    FMD_FMT_SINGLE,
    FMD_FMT_DOUBLE,
    FMD_FMT_WORD,
    FMD_FMT_LONG,
    FMD_FMT_PAIRED
  } fmd_fmt_t;

  typedef enum logic [3:0] {
    FMD_MD_NONE,
    FMD_MD_PRODUCT_LOW_SIGNED,
    FMD_MD_PRODUCT_HIGH_SIGNED,
    FMD_MD_PRODUCT_LOW_UNSIGNED,
    FMD_MD_PRODUCT_HIGH_UNSIGNED,
    FMD_MD_QUOTIENT_SIGNED,
    FMD_MD_REMAINDER_SIGNED,
    FMD_MD_QUOTIENT_UNSIGNED,
    FMD_MD_REMAINDER_UNSIGNED
  } fmd_md_t;

  typedef enum logic [2:0] {
    FMD_PC_NONE,
    FMD_PC_ADD_IMMEDIATE,
    FMD_PC_WORD_LOAD,
    FMD_PC_UNSIGNED_WORD_LOAD,
    FMD_PC_DOUBLEWORD_LOAD,
    FMD_PC_ADD_UPPER_IMMEDIATE,
    FMD_PC_ALIGNED_UPPER_IMMEDIATE
  } fmd_pc_t;

endpackage
